//--- core/phy_ext1_regs.sv
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module phy_ext1_regs (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic good_crc_pulse,
  input wire logic low_power_hold_input,
  input wire logic [1:0] phys_port_strap,
  output logic led_wake_blink,
  output logic [1:0] mdi_mode,
  output logic carrier_ext_disable,
  output logic [11:0] sleep_delay_ms,
  output logic [11:0] wake_interval_ms,
  output logic [1:0] mgmt_addr,
  output logic soft_reset_pulse,
  output logic irq
);
  import phy_ext1_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic region_e decode(input logic [7:0] a, input logic ok,
                                     input logic [15:0] page);
    logic [4:0] slot;
    slot = a[6:2];
    if (!ok || a[1:0] != 2'h0) begin
      decode = RG_NONE;
    end else if (a == IRQ_STATUS_ADDR) begin
      decode = RG_IRQ_STATUS;
    end else if (a == IRQ_MASK_ADDR) begin
      decode = RG_IRQ_MASK;
    end else if (a[7]) begin
      decode = RG_NONE;
    end else if (slot == SLOT_PAGE_SELECT) begin
      decode = RG_PAGE;
    end else if (slot <= SLOT_LOW_LAST || page == PAGE_MAIN) begin
      decode = RG_MAIN;
    end else if (page != PAGE_EXT_ONE) begin
      decode = RG_RSVD;
    end else if (slot == SLOT_CRC_COUNT) begin
      decode = RG_CRC;
    end else if (slot == SLOT_MODE_CTRL) begin
      decode = RG_MODE;
    end else if (slot == SLOT_CTRL_THREE) begin
      decode = RG_CTL3;
    end else begin
      decode = RG_RSVD;
    end
  endfunction

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic [15:0] main_mem [0:30];
  logic [15:0] page_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [7:0] rd_addr_reg;
  logic wr_ok_reg;
  logic rd_ok_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic accept;
  logic wr_fire;
  logic rd_fire;
  region_e wr_region;
  region_e rd_region;
  logic [31:0] rdata_next;
  logic [13:0] crc_cnt_reg;
  logic pkt_seen_reg;
  logic blink_en_reg;
  logic [1:0] mdi_sel_reg;
  logic carrier_dis_reg;
  logic [1:0] sleep_sel_reg;
  logic [1:0] wake_sel_reg;
  logic addr_rev_reg;
  logic [IRQ_BITS-1:0] irq_status_reg;
  logic [IRQ_BITS-1:0] irq_mask_reg;
  logic [IRQ_BITS-1:0] irq_event;
  logic irq_reg;
  logic soft_reset_reg;
  logic soft_reset;

  assign accept = hsel && htrans[1] && hready;
  assign wr_fire = wr_pend_reg;
  assign rd_fire = rd_pend_reg;
  assign wr_region = decode(wr_addr_reg, wr_ok_reg, page_reg);
  assign rd_region = decode(rd_addr_reg, rd_ok_reg, page_reg);
  assign soft_reset = wr_fire && wr_region == RG_MAIN &&
                      wr_addr_reg[6:2] == SLOT_PORT_CTRL && hwdata[SOFT_RESET_BIT];

  // Reads take one wait state so a write just ahead is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
      wr_ok_reg <= 1'b0;
      rd_ok_reg <= 1'b0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= accept && hwrite;
      rd_pend_reg <= accept && !hwrite;
      if (accept && hwrite) begin
        wr_addr_reg <= haddr[7:0];
        wr_ok_reg <= (haddr[31:8] == 24'h00_0000) && (hsize == 3'h2);
      end
      if (accept && !hwrite) begin
        rd_addr_reg <= haddr[7:0];
        rd_ok_reg <= (haddr[31:8] == 24'h00_0000) && (hsize == 3'h2);
        hreadyout_reg <= 1'b0;
      end else if (rd_pend_reg) begin
        hreadyout_reg <= 1'b1;
        hrdata_reg <= rdata_next;
      end
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    case (rd_region)
      RG_MAIN: rdata_next[15:0] = main_mem[rd_addr_reg[6:2]];
      RG_PAGE: rdata_next[15:0] = page_reg;
      RG_CRC: begin
        rdata_next[PKT_SEEN_BIT] = pkt_seen_reg;
        rdata_next[13:0] = crc_cnt_reg;
      end
      RG_MODE: begin
        rdata_next[BLINK_EN_BIT] = blink_en_reg;
        rdata_next[MDI_LSB+1:MDI_LSB] = mdi_sel_reg;
      end
      RG_CTL3: begin
        rdata_next[CARRIER_DIS_BIT] = carrier_dis_reg;
        rdata_next[SLEEP_LSB+1:SLEEP_LSB] = sleep_sel_reg;
        rdata_next[WAKE_LSB+1:WAKE_LSB] = wake_sel_reg;
        rdata_next[ADDR_REV_BIT] = addr_rev_reg;
      end
      RG_IRQ_STATUS: rdata_next[IRQ_BITS-1:0] = irq_status_reg;
      RG_IRQ_MASK: rdata_next[IRQ_BITS-1:0] = irq_mask_reg;
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // ****************************************************************
  // Page select and main space
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      page_reg <= PAGE_MAIN;
    end else if (wr_fire && wr_region == RG_PAGE) begin
      page_reg <= hwdata[15:0];
    end
  end

  // The port reset bit self-clears, so it is never stored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 31; i++) begin
        main_mem[i] <= 16'h0000;
      end
    end else if (wr_fire && wr_region == RG_MAIN) begin
      main_mem[wr_addr_reg[6:2]] <= (wr_addr_reg[6:2] == SLOT_PORT_CTRL) ?
                                    {1'b0, hwdata[14:0]} : hwdata[15:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= soft_reset;
    end
  end

  // ****************************************************************
  // Good-CRC counter
  // ****************************************************************
  logic crc_read;
  assign crc_read = rd_fire && rd_region == RG_CRC;

  // A packet in the clearing cycle is counted after the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_cnt_reg <= 14'h0000;
      pkt_seen_reg <= 1'b0;
    end else begin
      if (good_crc_pulse) begin
        pkt_seen_reg <= 1'b1;
        if (crc_read || soft_reset) begin
          crc_cnt_reg <= 14'h0001;
        end else if (crc_cnt_reg == CRC_COUNT_LAST) begin
          crc_cnt_reg <= 14'h0000;
        end else begin
          crc_cnt_reg <= crc_cnt_reg + 14'h0001;
        end
      end else if (crc_read || soft_reset) begin
        pkt_seen_reg <= 1'b0;
        crc_cnt_reg <= 14'h0000;
      end
    end
  end

  // ****************************************************************
  // Mode control and control three
  // ****************************************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      blink_en_reg <= 1'b0;
      mdi_sel_reg <= MDI_RESET;
      carrier_dis_reg <= CARRIER_DIS_RESET;
      addr_rev_reg <= 1'b0;
    end else if (soft_reset) begin
      blink_en_reg <= 1'b0;
      mdi_sel_reg <= MDI_RESET;
      carrier_dis_reg <= CARRIER_DIS_RESET;
      addr_rev_reg <= 1'b0;
    end else if (wr_fire && wr_region == RG_MODE) begin
      blink_en_reg <= hwdata[BLINK_EN_BIT];
      mdi_sel_reg <= hwdata[MDI_LSB+1:MDI_LSB];
    end else if (wr_fire && wr_region == RG_CTL3) begin
      carrier_dis_reg <= hwdata[CARRIER_DIS_BIT];
      addr_rev_reg <= hwdata[ADDR_REV_BIT];
    end
  end

  // Sticky timer fields ignore the software port reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_sel_reg <= SLEEP_RESET;
      wake_sel_reg <= WAKE_RESET;
    end else if (wr_fire && wr_region == RG_CTL3) begin
      sleep_sel_reg <= hwdata[SLEEP_LSB+1:SLEEP_LSB];
      wake_sel_reg <= hwdata[WAKE_LSB+1:WAKE_LSB];
    end
  end

  logic [11:0] sleep_ms_reg;
  logic [11:0] wake_ms_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_ms_reg <= SLEEP_MS_1;
      wake_ms_reg <= WAKE_MS_0;
    end else begin
      case (sleep_sel_reg)
        2'h0: sleep_ms_reg <= SLEEP_MS_0;
        2'h1: sleep_ms_reg <= SLEEP_MS_1;
        2'h2: sleep_ms_reg <= SLEEP_MS_2;
        default: sleep_ms_reg <= SLEEP_MS_3;
      endcase
      case (wake_sel_reg)
        2'h0: wake_ms_reg <= WAKE_MS_0;
        2'h1: wake_ms_reg <= WAKE_MS_1;
        2'h2: wake_ms_reg <= WAKE_MS_2;
        default: wake_ms_reg <= WAKE_MS_3;
      endcase
    end
  end

  // ****************************************************************
  // Hold input, LED blink, port address
  // ****************************************************************
  logic hold_s1_reg;
  logic hold_s2_reg;
  logic hold_s3_reg;
  logic hold_level_reg;
  logic hold_release;
  logic blink_reg;
  assign hold_release = hold_level_reg && (hold_s2_reg == hold_s3_reg) && !hold_s3_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_s1_reg <= 1'b0;
      hold_s2_reg <= 1'b0;
      hold_s3_reg <= 1'b0;
      hold_level_reg <= 1'b0;
      blink_reg <= 1'b0;
    end else begin
      hold_s1_reg <= low_power_hold_input;
      hold_s2_reg <= hold_s1_reg;
      hold_s3_reg <= hold_s2_reg;
      if (hold_s2_reg == hold_s3_reg) begin
        hold_level_reg <= hold_s3_reg;
      end
      blink_reg <= hold_release && blink_en_reg;
    end
  end

  // Strap is taken once after reset release; a static level is assumed
  logic strap_taken_reg;
  logic [1:0] port_reg;
  logic [1:0] mgmt_addr_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_taken_reg <= 1'b0;
      port_reg <= 2'h0;
      mgmt_addr_reg <= 2'h0;
    end else begin
      if (!strap_taken_reg) begin
        strap_taken_reg <= 1'b1;
        port_reg <= phys_port_strap;
      end
      mgmt_addr_reg <= addr_rev_reg ? ~port_reg : port_reg;
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_event[IRQ_GOOD_PKT] = good_crc_pulse;
  assign irq_event[IRQ_COUNT_WRAP] = good_crc_pulse && !crc_read && !soft_reset &&
                                     crc_cnt_reg == CRC_COUNT_LAST;
  assign irq_event[IRQ_HOLD_RELEASE] = hold_release;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_status_reg <= '0;
      irq_mask_reg <= '0;
      irq_reg <= 1'b0;
    end else begin
      if (wr_fire && wr_region == RG_IRQ_STATUS) begin
        irq_status_reg <= (irq_status_reg & ~hwdata[IRQ_BITS-1:0]) | irq_event;
      end else begin
        irq_status_reg <= irq_status_reg | irq_event;
      end
      if (wr_fire && wr_region == RG_IRQ_MASK) begin
        irq_mask_reg <= hwdata[IRQ_BITS-1:0];
      end
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = 1'b0;
  assign led_wake_blink = blink_reg;
  assign mdi_mode = mdi_sel_reg;
  assign carrier_ext_disable = carrier_dis_reg;
  assign sleep_delay_ms = sleep_ms_reg;
  assign wake_interval_ms = wake_ms_reg;
  assign mgmt_addr = mgmt_addr_reg;
  assign soft_reset_pulse = soft_reset_reg;
  assign irq = irq_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_page_select: assert property (
    wr_fire && wr_region == RG_PAGE && hwdata[15:0] == PAGE_EXT_ONE |=> page_reg == PAGE_EXT_ONE)
    else $error("page one not selected");
  chk_page_restore: assert property (
    wr_fire && wr_region == RG_PAGE && hwdata[15:0] == PAGE_MAIN |=> page_reg == PAGE_MAIN)
    else $error("main page not restored");
  chk_mode_reached: assert property (
    wr_fire && wr_region == RG_MODE && !soft_reset |=> mdi_sel_reg == $past(hwdata[3:2]))
    else $error("mode write lost");
  chk_low_slots: assert property (
    wr_fire && wr_ok_reg && wr_addr_reg[7:6] == 2'h0 && wr_addr_reg[1:0] == 2'h0 |->
    wr_region == RG_MAIN)
    else $error("low slot decoded by page");
  chk_seen_flag: assert property (
    good_crc_pulse |=> pkt_seen_reg)
    else $error("packet flag not set");
  chk_count_wrap: assert property (
    good_crc_pulse && !crc_read && !soft_reset && crc_cnt_reg == CRC_COUNT_LAST |=>
    crc_cnt_reg == 0)
    else $error("count did not wrap");
  chk_count_step: assert property (
    good_crc_pulse && !crc_read && !soft_reset && crc_cnt_reg < CRC_COUNT_LAST |=>
    crc_cnt_reg == $past(crc_cnt_reg) + 14'h0001)
    else $error("count did not step");
  chk_read_clear: assert property (
    crc_read && !good_crc_pulse |=> crc_cnt_reg == 0 && !pkt_seen_reg && hreadyout)
    else $error("read did not clear");
  chk_blink_cause: assert property (
    led_wake_blink |-> $past(hold_release) && $past(blink_en_reg))
    else $error("blink without cause");
  chk_sticky_keep: assert property (
    soft_reset |=> sleep_sel_reg == $past(sleep_sel_reg) && carrier_dis_reg)
    else $error("sticky field lost");
  chk_rsvd_zero: assert property (
    rd_fire && rd_region == RG_RSVD |=> hrdata == 32'h0000_0000 && hreadyout)
    else $error("reserved slot not zero");
  chk_irq_level: assert property (
    |(irq_status_reg & irq_mask_reg) |=> irq)
    else $error("interrupt not raised");
  // A clear written in the event cycle must not swallow the event
  chk_event_sticky: assert property (
    irq_event[IRQ_GOOD_PKT] |=> irq_status_reg[IRQ_GOOD_PKT])
    else $error("event lost to clear");

  cov_page_one_read: cover property (rd_fire && rd_region == RG_CRC && pkt_seen_reg);
  cov_count_wrap: cover property (irq_event[IRQ_COUNT_WRAP]);
  cov_blink: cover property (led_wake_blink);
  cov_soft_reset: cover property (soft_reset);
endmodule // phy_ext1_regs

//--- core/phy_ext1_pkg.sv
package phy_ext1_pkg;
  // ****************************************************************
  // Register slots (index); byte address is four times the index; the IRQ registers are given by byte address
  // ****************************************************************
  localparam logic [4:0] SLOT_LOW_LAST = 5'h0F;
  localparam logic [4:0] SLOT_CRC_COUNT = 5'h12;
  localparam logic [4:0] SLOT_MODE_CTRL = 5'h13;
  localparam logic [4:0] SLOT_CTRL_THREE = 5'h14;
  localparam logic [4:0] SLOT_PAGE_SELECT = 5'h1F;
  localparam logic [4:0] SLOT_PORT_CTRL = 5'h00;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'h80;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'h84;
  // ****************************************************************
  // Page select values
  // ****************************************************************
  localparam logic [15:0] PAGE_MAIN = 16'h0000;
  localparam logic [15:0] PAGE_EXT_ONE = 16'h0001;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int SOFT_RESET_BIT = 15;
  localparam int PKT_SEEN_BIT = 15;
  localparam int BLINK_EN_BIT = 11;
  localparam int MDI_LSB = 2;
  localparam int CARRIER_DIS_BIT = 15;
  localparam int SLEEP_LSB = 13;
  localparam int WAKE_LSB = 11;
  localparam int ADDR_REV_BIT = 9;
  localparam logic CARRIER_DIS_RESET = 1'b1;
  localparam logic [1:0] SLEEP_RESET = 2'h1;
  localparam logic [1:0] WAKE_RESET = 2'h0;
  localparam logic [1:0] MDI_RESET = 2'h0;
  localparam logic [13:0] CRC_COUNT_LAST = 14'h270F;
  // ****************************************************************
  // Interrupt status bits
  // ****************************************************************
  localparam int IRQ_GOOD_PKT = 0;
  localparam int IRQ_COUNT_WRAP = 1;
  localparam int IRQ_HOLD_RELEASE = 2;
  localparam int IRQ_BITS = 3;
  // ****************************************************************
  // Timer values in milliseconds
  // ****************************************************************
  localparam logic [11:0] SLEEP_MS_0 = 12'h3E8;
  localparam logic [11:0] SLEEP_MS_1 = 12'h7D0;
  localparam logic [11:0] SLEEP_MS_2 = 12'hBB8;
  localparam logic [11:0] SLEEP_MS_3 = 12'hFA0;
  localparam logic [11:0] WAKE_MS_0 = 12'h0A0;
  localparam logic [11:0] WAKE_MS_1 = 12'h190;
  localparam logic [11:0] WAKE_MS_2 = 12'h320;
  localparam logic [11:0] WAKE_MS_3 = 12'h7D0;
  typedef enum logic [2:0] {
    REG_NONE, REG_MAIN, REG_PAGE, REG_CRC, REG_MODE, REG_CTL3, REG_RSVD, REG_IRQ_ST
  } region_base_e;
  typedef enum logic [3:0] {
    RG_NONE, RG_MAIN, RG_PAGE, RG_CRC, RG_MODE, RG_CTL3, RG_RSVD, RG_IRQ_STATUS,
    RG_IRQ_MASK
  } region_e;
endpackage

//--- verification/mgmt_host.sv
`timescale 1ns/1ps
// ****************************************************************
// Management host model driving the register bus
// ****************************************************************
module mgmt_host (
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  output logic hung
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    hung = 1'b0;
  end
  // Bounded wait; a stuck slave raises hung instead of hanging the run
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    if (hready !== 1'b1) hung <= 1'b1;
  endtask
  // Page select writes of 0x0001 and 0x0000 are issued here too
  task automatic bus_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b1;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    wait_ready();
    // Released data is inverted so a stale value is never mistaken for valid
    hwdata <= ~{16'h0000, d};
  endtask
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= 1'b0;
    wait_ready();
    htrans <= 2'h0;
    wait_ready();
    d = hrdata;
  endtask
endmodule // mgmt_host

//--- verification/tb_phy_ext1_regs.sv
`timescale 1ns/1ps
module tb_phy_ext1_regs;
  import phy_ext1_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, good_crc_pulse, low_power_hold_input;
  logic led_wake_blink, carrier_ext_disable, soft_reset_pulse, irq, host_hung;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, phys_port_strap, mdi_mode, mgmt_addr;
  logic [2:0] hsize;
  logic [11:0] sleep_delay_ms, wake_interval_ms;
  int n_mismatch = 0;
  int check_count = 0;
  phy_ext1_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .good_crc_pulse(good_crc_pulse),
    .low_power_hold_input(low_power_hold_input), .phys_port_strap(phys_port_strap),
    .led_wake_blink(led_wake_blink), .mdi_mode(mdi_mode),
    .carrier_ext_disable(carrier_ext_disable), .sleep_delay_ms(sleep_delay_ms),
    .wake_interval_ms(wake_interval_ms), .mgmt_addr(mgmt_addr),
    .soft_reset_pulse(soft_reset_pulse), .irq(irq));
  mgmt_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hung(host_hung));
  initial hclk = 1'b0;
  always #5 hclk = ~hclk;
  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic close_out();
    if (n_mismatch == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge host_hung) begin
    n_mismatch++;
    close_out();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  function automatic logic [7:0] ad(input logic [4:0] s);
    return {1'b0, s, 2'b00};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_host.bus_write(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    i_host.bus_read(a, d);
    chk(d, e);
  endtask
  task automatic pkt(input int n);
    repeat (n) begin
      @(posedge hclk);
      good_crc_pulse <= 1'b1;
      @(posedge hclk);
      good_crc_pulse <= 1'b0;
    end
  endtask
  // The timer outputs and mgmt_addr lag their register by a cycle, so let a few edges pass
  task automatic settle();
    repeat (3) @(posedge hclk);
    #1;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    chk({31'h0, carrier_ext_disable}, 32'h1);
    chk({20'h0, sleep_delay_ms}, 32'h7D0);
    chk({20'h0, wake_interval_ms}, 32'hA0);
    chk({31'h0, hresp}, 32'h0);
    wr(ad(SLOT_PAGE_SELECT), PAGE_EXT_ONE);
    rdc(ad(SLOT_CRC_COUNT), 32'h0);
    rdc(ad(SLOT_MODE_CTRL), 32'h0);
    rdc(ad(SLOT_CTRL_THREE), 32'hA000);
  endtask
  task automatic t_paging();
    wr(ad(SLOT_PAGE_SELECT), PAGE_MAIN);
    wr(ad(SLOT_CRC_COUNT), 16'h1234);
    wr(ad(5'h05), 16'h0055);
    wr(ad(SLOT_PAGE_SELECT), PAGE_EXT_ONE);
    rdc(ad(SLOT_CRC_COUNT), 32'h0);
    rdc(ad(5'h05), 32'h55);
    wr(ad(5'h10), 16'hFFFF);
    rdc(ad(5'h10), 32'h0);
    rdc(ad(5'h17), 32'h0);
    rdc(8'h88, 32'h0);
    // A page value other than main or page one leaves the upper slots empty
    wr(ad(SLOT_PAGE_SELECT), 16'h0002);
    rdc(ad(SLOT_PAGE_SELECT), 32'h2);
    rdc(ad(SLOT_CRC_COUNT), 32'h0);
    wr(ad(SLOT_PAGE_SELECT), PAGE_MAIN);
    rdc(ad(SLOT_CRC_COUNT), 32'h1234);
    rdc(ad(5'h05), 32'h55);
    wr(ad(SLOT_PAGE_SELECT), PAGE_EXT_ONE);
  endtask
  task automatic t_count();
    pkt(3);
    rdc(ad(SLOT_CRC_COUNT), 32'h8003);
    rdc(ad(SLOT_CRC_COUNT), 32'h0);
  endtask
  // Full modulus run: the count must roll to zero, never stick at the top
  task automatic t_wrap();
    wr(IRQ_STATUS_ADDR, 16'h0007);
    pkt(10000);
    rdc(ad(SLOT_CRC_COUNT), 32'h8000);
    rdc(IRQ_STATUS_ADDR, 32'h3);
  endtask
  task automatic t_mode();
    for (int i = 0; i < 4; i++) begin
      wr(ad(SLOT_MODE_CTRL), {12'h000, 2'(i), 2'h0});
      settle();
      chk({30'h0, mdi_mode}, 32'(i));
    end
    wr(ad(SLOT_MODE_CTRL), 16'hFFFF);
    rdc(ad(SLOT_MODE_CTRL), 32'h080C);
  endtask
  task automatic t_blink(input logic en);
    logic seen;
    wr(ad(SLOT_MODE_CTRL), {4'h0, en, 11'h000});
    @(posedge hclk);
    low_power_hold_input <= 1'b1;
    repeat (8) @(posedge hclk);
    low_power_hold_input <= 1'b0;
    seen = 1'b0;
    repeat (20) begin
      @(posedge hclk);
      #1;
      if (led_wake_blink === 1'b1) seen = 1'b1;
    end
    chk({31'h0, seen}, {31'h0, en});
  endtask
  task automatic t_ctrl3();
    int wt[4] = '{160, 400, 800, 2000};
    for (int i = 0; i < 4; i++) begin
      wr(ad(SLOT_CTRL_THREE), {1'b0, 2'(i), 2'(i), 1'b0, 1'b1, 9'h000});
      settle();
      chk({20'h0, sleep_delay_ms}, 32'(1000 * (i + 1)));
      chk({20'h0, wake_interval_ms}, 32'(wt[i]));
      chk({31'h0, carrier_ext_disable}, 32'h0);
      chk({30'h0, mgmt_addr}, 32'h2);
    end
    wr(ad(SLOT_CTRL_THREE), 16'h0000);
    settle();
    chk({30'h0, mgmt_addr}, 32'h1);
  endtask
  // Soft reset keeps the timer fields; only a hardware reset restores them
  task automatic t_sticky();
    wr(ad(SLOT_CTRL_THREE), 16'h7200);
    wr(ad(SLOT_PORT_CTRL), 16'h8000);
    #1;
    chk({31'h0, soft_reset_pulse}, 32'h1);
    settle();
    chk({31'h0, soft_reset_pulse}, 32'h0);
    rdc(ad(SLOT_CTRL_THREE), 32'hF000);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    wr(ad(SLOT_PAGE_SELECT), PAGE_EXT_ONE);
    rdc(ad(SLOT_CTRL_THREE), 32'hA000);
  endtask
  task automatic t_irq();
    wr(IRQ_STATUS_ADDR, 16'h0007);
    wr(IRQ_MASK_ADDR, 16'h0001);
    pkt(1);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(IRQ_STATUS_ADDR, 16'h0001);
    settle();
    chk({31'h0, irq}, 32'h0);
    wr(IRQ_MASK_ADDR, 16'h0000);
    pkt(1);
    settle();
    chk({31'h0, irq}, 32'h0);
    rdc(IRQ_STATUS_ADDR, 32'h1);
    rdc(IRQ_MASK_ADDR, 32'h0);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    hresetn = 1'b0;
    good_crc_pulse = 1'b0;
    low_power_hold_input = 1'b0;
    phys_port_strap = 2'h1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_paging();
    t_count();
    t_wrap();
    t_mode();
    t_blink(1'b0);
    t_blink(1'b1);
    t_ctrl3();
    t_irq();
    t_sticky();
    close_out();
  end
endmodule // tb_phy_ext1_regs
